// ==== hdl/udt_timer.sv ====
// 8-bit up/down timer with interval and auto-reload modes, APB slave.
// Assumes APB master on pclk; event and direction pins are asynchronous.
//
// Summary of operation
// - Mode bit: 0 interval, 1 auto-reload; resets to interval.
// - With hardware direction off, software bit picks up (0) or down (1).
// - With hardware direction on, pin high counts down, low counts up.
// - Mode bits 4 and 3 read as one; writes ignored.
// - Source codes 001..110 pick divide 2048..8; 111 picks event pin edges.
// - Source code 000, the reset value, picks divide by 8192.
// - Event edge polarity follows the edge-select bit in the interrupt register.
// - Eight-bit counter steps by one per selected input pulse.
// - Counter value changes from the bus only through load writes; reads never disturb counting.
// - Overflow past ff or underflow past 00 sets the wrap flag.
// - Interrupt requested while flag set and enable is one.
// - Interval mode wraps to 00 or ff and keeps direction.
// - Writing load value also loads the counter at once.
// - Auto-reload mode reloads the load value on every wrap.
// - Counter and load share one address: read counter, write load.
// - Reset gives counter 00, load 00, mode 18.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module udt_timer (
	// Clock, reset and freeze
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [udt_pkg::UDT_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins
	input wire logic event_input_pin,
	input wire logic direction_pin,
	// Interrupt request
	output logic wrap_irq_req
);
	import udt_pkg::*;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] mode_r;
	logic [7:0] count_r;
	logic [7:0] load_r;
	logic flag_r;
	logic enable_r;
	logic edge_sel_r;
	logic [UDT_PRE_W-1:0] pre_r;
	logic ev_s1_r;
	logic ev_s2_r;
	logic ev_s3_r;
	logic dir_s1_r;
	logic dir_s2_r;
	logic irq_r;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic [1:0] idx;
	logic addr_ok;
	logic access;
	logic wr_mode;
	logic wr_load;
	logic wr_irq;

	assign idx = paddr[3:2];
	assign addr_ok = (paddr[1:0] == 2'h0) && (idx != 2'h3);
	// Writes land on the edge that samples pready high
	assign access = psel && penable && pready;
	assign wr_mode = access && pwrite && pstrb[0] && (idx == UDT_IDX_MODE) && addr_ok;
	assign wr_load = access && pwrite && pstrb[0] && (idx == UDT_IDX_COUNT) && addr_ok;
	assign wr_irq = access && pwrite && pstrb[0] && (idx == UDT_IDX_IRQ) && addr_ok;

	// One wait state: pready rises the cycle after penable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else if (clk_en) begin
			pready <= psel && penable && !pready;
		end
	end

	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		unique case (idx)
			UDT_IDX_MODE: rd_byte = mode_r | UDT_MODE_RSVD_MASK;
			UDT_IDX_COUNT: rd_byte = count_r;
			UDT_IDX_IRQ: rd_byte = {5'h00, edge_sel_r, enable_r, flag_r};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			if (psel && penable && !pready) begin
				prdata <= (addr_ok && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
				pslverr <= !addr_ok;
			end else begin
				prdata <= 32'h0000_0000;
				pslverr <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Mode register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= UDT_MODE_RESET;
		end else if (clk_en && wr_mode) begin
			// Reserved bits keep their fixed ones
			mode_r <= (pwdata[7:0] & ~UDT_MODE_RSVD_MASK) | UDT_MODE_RSVD_MASK;
		end
	end

	logic reload_mode;
	logic hw_direction_sel;
	logic sw_direction_bit;
	udt_src_type count_source_sel;
	assign reload_mode = mode_r[UDT_MODE_RELOAD_BIT];
	assign hw_direction_sel = mode_r[UDT_MODE_HWDIR_BIT];
	assign sw_direction_bit = mode_r[UDT_MODE_SWDIR_BIT];
	assign count_source_sel = udt_src_type'(mode_r[2:0]);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_s1_r <= 1'b0;
			ev_s2_r <= 1'b0;
			ev_s3_r <= 1'b0;
		end else if (clk_en) begin
			ev_s1_r <= event_input_pin;
			ev_s2_r <= ev_s1_r;
			ev_s3_r <= ev_s2_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_s1_r <= 1'b0;
			dir_s2_r <= 1'b0;
		end else if (clk_en) begin
			dir_s1_r <= direction_pin;
			dir_s2_r <= dir_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// Count source
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_r <= '0;
		end else if (clk_en) begin
			pre_r <= pre_r + 1'b1;
		end
	end

	logic [UDT_PRE_W-1:0] tap_mask;
	always_comb begin
		tap_mask = UDT_DIV_8192;
		unique case (count_source_sel)
			UDT_SRC_D8192: tap_mask = UDT_DIV_8192;
			UDT_SRC_D2048: tap_mask = UDT_DIV_2048;
			UDT_SRC_D512: tap_mask = UDT_DIV_512;
			UDT_SRC_D256: tap_mask = UDT_DIV_256;
			UDT_SRC_D128: tap_mask = UDT_DIV_128;
			UDT_SRC_D32: tap_mask = UDT_DIV_32;
			UDT_SRC_D8: tap_mask = UDT_DIV_8;
			UDT_SRC_EXT: tap_mask = UDT_DIV_8192;
		endcase
	end

	logic tap_tick;
	logic ev_edge;
	logic count_tick;
	// Tap fires once per divisor period, one cycle wide
	assign tap_tick = ((pre_r & tap_mask) == tap_mask);
	// Edge seen between stable second and third stages
	assign ev_edge = edge_sel_r ? (ev_s2_r && !ev_s3_r) : (!ev_s2_r && ev_s3_r);
	assign count_tick = (mode_r[2:0] == UDT_SRC_EXTERNAL) ? ev_edge : tap_tick;

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	logic count_down;
	logic wrap;
	assign count_down = hw_direction_sel ? dir_s2_r : sw_direction_bit;
	assign wrap = count_tick && (count_down ? (count_r == UDT_COUNT_MIN)
		: (count_r == UDT_COUNT_MAX));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_r <= UDT_LOAD_RESET;
		end else if (clk_en && wr_load) begin
			load_r <= pwdata[7:0];
		end
	end

	// A bus load beats a coincident count pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= UDT_COUNT_RESET;
		end else if (clk_en) begin
			if (wr_load) begin
				count_r <= pwdata[7:0];
			end else if (wrap && reload_mode) begin
				count_r <= load_r;
			end else if (count_tick) begin
				// Plain step also wraps ff->00 and 00->ff in interval mode
				count_r <= count_down ? count_r - 1'b1 : count_r + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Wrap flag, enable, edge select and request
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_r <= 1'b0;
			edge_sel_r <= 1'b0;
		end else if (clk_en && wr_irq) begin
			enable_r <= pwdata[UDT_IRQ_ENABLE_BIT];
			edge_sel_r <= pwdata[UDT_IRQ_EDGE_BIT];
		end
	end

	// Write one to clear; a wrap in the same cycle keeps it set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_r <= 1'b0;
		end else if (clk_en) begin
			if (wrap) begin
				flag_r <= 1'b1;
			end else if (wr_irq && pwdata[UDT_IRQ_FLAG_BIT]) begin
				flag_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else if (clk_en) begin
			irq_r <= flag_r && enable_r;
		end
	end
	assign wrap_irq_req = irq_r;

endmodule : udt_timer

`default_nettype wire

// ==== hdl/udt_pkg.sv ====
// Constants for the 8-bit up/down reload timer: register map, field
// positions, reset values and prescaler divisors.
// Assumes a 32-bit APB with one aligned word per register.
package udt_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [1:0] UDT_IDX_MODE = 2'h0;
	localparam logic [1:0] UDT_IDX_COUNT = 2'h1;
	localparam logic [1:0] UDT_IDX_IRQ = 2'h2;
	localparam int UDT_ADDR_W = 4;

	// ----------------------------------------------------------------
	// Mode register fields
	// ----------------------------------------------------------------
	localparam int UDT_MODE_RELOAD_BIT = 7;
	localparam int UDT_MODE_HWDIR_BIT = 6;
	localparam int UDT_MODE_SWDIR_BIT = 5;
	localparam logic [7:0] UDT_MODE_RSVD_MASK = 8'h18;
	localparam logic [7:0] UDT_MODE_RESET = 8'h18;
	localparam logic [2:0] UDT_SRC_EXTERNAL = 3'h7;

	// ----------------------------------------------------------------
	// Interrupt register fields
	// ----------------------------------------------------------------
	localparam int UDT_IRQ_FLAG_BIT = 0;
	localparam int UDT_IRQ_ENABLE_BIT = 1;
	localparam int UDT_IRQ_EDGE_BIT = 2;

	// ----------------------------------------------------------------
	// Counter and load reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] UDT_COUNT_RESET = 8'h00;
	localparam logic [7:0] UDT_LOAD_RESET = 8'h00;
	localparam logic [7:0] UDT_COUNT_MAX = 8'hff;
	localparam logic [7:0] UDT_COUNT_MIN = 8'h00;

	// ----------------------------------------------------------------
	// Prescaler taps, as divisor minus one
	// ----------------------------------------------------------------
	localparam int UDT_PRE_W = 13;
	localparam logic [12:0] UDT_DIV_8192 = 13'h1fff;
	localparam logic [12:0] UDT_DIV_2048 = 13'h07ff;
	localparam logic [12:0] UDT_DIV_512 = 13'h01ff;
	localparam logic [12:0] UDT_DIV_256 = 13'h00ff;
	localparam logic [12:0] UDT_DIV_128 = 13'h007f;
	localparam logic [12:0] UDT_DIV_32 = 13'h001f;
	localparam logic [12:0] UDT_DIV_8 = 13'h0007;

	typedef enum logic [2:0] {
		UDT_SRC_D8192,
		UDT_SRC_D2048,
		UDT_SRC_D512,
		UDT_SRC_D256,
		UDT_SRC_D128,
		UDT_SRC_D32,
		UDT_SRC_D8,
		UDT_SRC_EXT
	} udt_src_type;

endpackage : udt_pkg

// ==== dv/udt_timer_props.sv ====
// Checker for the up/down timer: APB timing, read data and interrupt.
// Sees only udt_timer ports; bound to every instance of it.
`timescale 1ns/100ps
`default_nettype none

module udt_timer_props
	import udt_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [udt_pkg::UDT_ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Interrupt
	input wire logic wrap_irq_req
);
	// ----------
	// Assertions
	// ----------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && !pready;
	endsequence
	a_ready_one_wait: assert property (s_setup ##1 s_access |=> pready)
		else $error("pready late after access phase");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_cause: assert property (pready |-> $past(psel && penable))
		else $error("pready without access phase");
	a_err_unmapped: assert property (pready && paddr[3:2] == 2'h3 |-> pslverr)
		else $error("unmapped access not refused");
	a_err_clean: assert property (pready && paddr[3:2] != 2'h3 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access refused");
	a_mode_rsvd_one: assert property (pready && !pwrite && paddr == 4'h0 |->
		(prdata[7:0] & UDT_MODE_RSVD_MASK) == UDT_MODE_RSVD_MASK)
		else $error("reserved mode bits not one");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("read data above byte not zero");
	a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("bus outputs active while idle");
	a_irq_match: assert property (pready && !pwrite && paddr == 4'h8 |->
		wrap_irq_req == (prdata[0] && prdata[1]))
		else $error("interrupt request disagrees with flag and enable");
endmodule : udt_timer_props

bind udt_timer udt_timer_props i_udt_timer_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .wrap_irq_req);
`default_nettype wire

// ==== dv/udt_pin_model.sv ====
// Far side of the timer: event input pin and direction pin.
// Assumes its tasks are called just after a rising pclk edge.
`timescale 1ns/100ps
`default_nettype none

module udt_pin_model (
	// Clock
	input wire logic pclk,
	// Pins
	output var logic event_input_pin,
	output var logic direction_pin
);
	// Event pin idles high: a pulse is a falling then a rising edge
	initial begin
		event_input_pin = 1'b1;
		direction_pin = 1'b0;
	end
	// Six cycles a level, longer than sync plus edge detect
	task automatic drive(input logic v);
		event_input_pin <= v;
		repeat (6) @(posedge pclk);
	endtask : drive
	task automatic set_dir(input logic v);
		direction_pin <= v;
		@(posedge pclk);
	endtask : set_dir
endmodule : udt_pin_model
`default_nettype wire

// ==== dv/udt_timer_tb.sv ====
// Self-checking bench for the up/down timer over APB.
// Assumes the design, its checker and the pin model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module udt_timer_tb;
	import udt_pkg::*;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, er;
	logic event_input_pin, direction_pin, wrap_irq_req;
	logic [UDT_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd, rd2;
	logic [3:0] pstrb;
	int failures, samples_checked, cyc;
	int dv[7] = '{8192, 2048, 512, 256, 128, 32, 8};

	udt_timer i_udt_timer (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .event_input_pin, .direction_pin,
		.wrap_irq_req);
	udt_pin_model i_udt_pin_model (.pclk, .event_input_pin, .direction_pin);

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			failures++;
			tally_and_finish();
		end
	end

	// ----------
	// Bus tasks
	// ----------
	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t got %h expected %h", $time, g, e);
		end
	endtask : chk32
	task automatic chk1(input logic g, input logic e);
		chk32({31'h0, g}, {31'h0, e});
	endtask : chk1
	// Idle cycle after each transfer, so psel is never set twice at one edge
	// Waits for pready without a limit of its own; the cycle ceiling ends a hang
	task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk32(rd, {24'h0, e});
	endtask : rchk
	task automatic ev(input int n);
		repeat (n) begin
			i_udt_pin_model.drive(1'b0);
			i_udt_pin_model.drive(1'b1);
		end
	endtask : ev

	// ----------
	// Tests
	// ----------
	initial begin
		presetn = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 4'h0;
		pwdata = 32'h0;
		pstrb = 4'hf;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(4'h0, 8'h18);
		rchk(4'h4, 8'h00);
		apb(1'b1, 4'h0, 8'he7);
		rchk(4'h0, 8'hff);
		apb(1'b1, 4'h0, 8'ha7);
		ev(1);
		rchk(4'h4, 8'h00);
		rchk(4'h8, 8'h01);
		apb(1'b1, 4'h8, 8'h02);
		repeat (2) @(posedge pclk);
		chk1(wrap_irq_req, 1'b1);
		apb(1'b1, 4'h8, 8'h03);
		repeat (2) @(posedge pclk);
		chk1(wrap_irq_req, 1'b0);
		apb(1'b1, 4'h0, 8'h07);
		rchk(4'h0, 8'h1f);
		apb(1'b1, 4'h4, 8'h5a);
		rchk(4'h4, 8'h5a);
		apb(1'b1, 4'h4, 8'hfe);
		ev(3);
		rchk(4'h4, 8'h01);
		rchk(4'h8, 8'h03);
		apb(1'b1, 4'h8, 8'h01);
		apb(1'b1, 4'h0, 8'h27);
		apb(1'b1, 4'h4, 8'h01);
		ev(2);
		rchk(4'h4, 8'hff);
		apb(1'b1, 4'h0, 8'h67);
		i_udt_pin_model.set_dir(1'b1);
		ev(1);
		rchk(4'h4, 8'hfe);
		i_udt_pin_model.set_dir(1'b0);
		ev(2);
		rchk(4'h4, 8'h00);
		apb(1'b1, 4'h0, 8'h87);
		apb(1'b1, 4'h4, 8'hfe);
		ev(2);
		rchk(4'h4, 8'hfe);
		apb(1'b1, 4'h8, 8'h05);
		i_udt_pin_model.drive(1'b0);
		rchk(4'h4, 8'hfe);
		i_udt_pin_model.drive(1'b1);
		rchk(4'h4, 8'hff);
		apb(1'b1, 4'h8, 8'h01);
		apb(1'b0, 4'hc, 8'h00);
		chk1(er, 1'b1);
		chk32(rd, 32'h0);
		apb(1'b1, 4'h1, 8'h55);
		chk1(er, 1'b1);
		rchk(4'h0, 8'h9f);
		// Write with the low byte strobe off must leave load and count alone
		pstrb <= 4'he;
		apb(1'b1, 4'h4, 8'h33);
		pstrb <= 4'hf;
		rchk(4'h4, 8'hff);
		for (int c = 0; c < 7; c++) begin
			apb(1'b1, 4'h0, 8'(c));
			apb(1'b0, 4'h4, 8'h00);
			rd2 = rd;
			repeat (2 * dv[c] - 4) @(posedge pclk);
			apb(1'b0, 4'h4, 8'h00);
			chk32({24'h0, rd[7:0] - rd2[7:0]}, 32'h2);
		end
		// Freeze: 100 stalled edges on the divide-by-8 source add no steps
		rd2 = rd;
		clk_en <= 1'b0;
		repeat (100) @(posedge pclk);
		clk_en <= 1'b1;
		repeat (12) @(posedge pclk);
		apb(1'b0, 4'h4, 8'h00);
		chk32({24'h0, rd[7:0] - rd2[7:0]}, 32'h2);
		tally_and_finish();
	end
endmodule : udt_timer_tb
`default_nettype wire
